// *** uhrs_dev_model.sv ***
`timescale 1ns/1ns
// Downstream device: measures how long each K line state lasts, and each SE0 state not followed directly by K
module uhrs_dev_model
  import uhrs_pkg::*;
(
  input  wire logic          i_sys_clk,
  input  wire uhrs_line_type i_line,
  output logic [15:0]        o_k_len,
  output logic [15:0]        o_se0_len
);
  logic [15:0]   run = 16'h0000;
  uhrs_line_type last = UHRS_LINE_J;
  initial o_k_len = 16'h0000;
  initial o_se0_len = 16'h0000;
  // Length latched when the state changes, so only finished runs show
  always @(posedge i_sys_clk) begin
    run <= (i_line == last) ? run + 16'h0001 : 16'h0001;
    if (i_line != last && last == UHRS_LINE_K) o_k_len <= run;
    if (i_line != last && last == UHRS_LINE_SE0) o_se0_len <= run;
    // A new K starts a fresh measurement, so no stale length survives
    if (i_line == UHRS_LINE_K && last != UHRS_LINE_K) begin
      o_k_len   <= 16'h0000;
      o_se0_len <= 16'h0000;
    end
    last <= i_line;
  end
endmodule

// *** uhrs_map.svh ***
`ifndef UHRS_MAP_SVH
`define UHRS_MAP_SVH

// ----------------------------------------------------------------
// Command, state and mode codes
// ----------------------------------------------------------------
`define UHRS_CMD_W          4
`define UHRS_CMD_IDLE       4'h0
`define UHRS_CMD_RESUME     4'h5
`define UHRS_CMD_OPER       4'h6
`define UHRS_STATE_W        3
`define UHRS_STATE_SUSPEND  3'h3
`define UHRS_STATE_RESUME   3'h4
`define UHRS_STATE_OPER     3'h5
`define UHRS_TRANSCEIVER_OPERATION_MODE_W       2
`define UHRS_TRANSCEIVER_OPERATION_MODE_NORMAL  2'h0
`define UHRS_TRANSCEIVER_OPERATION_MODE_RAW     2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define UHRS_CLK_HZ         25000000
`define UHRS_RSM_K_US       20000
`define UHRS_RSM_K_CYC      ((`UHRS_RSM_K_US * (`UHRS_CLK_HZ / 1000000)) + 1)
`define UHRS_CMP_MIN_US     90
`define UHRS_CMP_MAX_US     110
`define UHRS_CMP_US         100
`define UHRS_CMP_CYC        (`UHRS_CMP_US * (`UHRS_CLK_HZ / 1000000))
`define UHRS_SOF_MIN_US     900
`define UHRS_SOF_MAX_US     1100
`define UHRS_SOF_US         1000
`define UHRS_SOF_CYC        (`UHRS_SOF_US * (`UHRS_CLK_HZ / 1000000))
`define UHRS_LS_BIT_NS      667
`define UHRS_LS_BIT_CYC     ((`UHRS_LS_BIT_NS * (`UHRS_CLK_HZ / 1000000) + 999) / 1000)
`define UHRS_EOP_SE0_BITS   2
`define UHRS_EOP_J_BITS     1

`endif

// *** uhrs_pkg.sv ***
package uhrs_pkg;
  `include "uhrs_map.svh"

  typedef enum logic [1:0] {
    UHRS_LINE_J,
    UHRS_LINE_K,
    UHRS_LINE_SE0
  } uhrs_line_type;

  // Transceiver drive bundle
  typedef struct packed {
    logic [`UHRS_TRANSCEIVER_OPERATION_MODE_W-1:0] op_mode;
    logic                      raw_drive;
    uhrs_line_type             line;
  } uhrs_xcvr_type;

  // Detector enables
  typedef struct packed {
    logic disconnect_det_en;
    logic wakeup_det_en;
  } uhrs_det_type;
endpackage

// *** uhrs_sequencer.sv ***
// How it works
// - A resume request code runs the whole resume sequence in hardware with no more firmware.
// - The host state monitor shows resume in the cycle after the request is taken.
// - Disconnect and remote wakeup detection turn off at time zero for the whole resume.
// - At time zero the transceiver goes to raw drive and a steady K is driven.
// - The K state is held for more than 20 ms after time zero.
// - The K ends with an end-of-packet timed in low-speed bit times for either speed.
// - Resume complete is flagged 90 to 110 us after the K signalling ends.
// - An operational request code returns the transceiver to normal drive.
// - Full speed: first SOF goes 0.9 to 1.1 ms after the operational request.
// - Low speed: first KeepAlive goes 0.9 to 1.1 ms after the operational request.
`timescale 1ns/1ns
`include "uhrs_map.svh"

module uhrs_sequencer
  import uhrs_pkg::*;
#(
  parameter int RSM_K_CYC   = `UHRS_RSM_K_CYC,
  parameter int CMP_CYC     = `UHRS_CMP_CYC,
  parameter int SOF_CYC     = `UHRS_SOF_CYC,
  parameter int LS_BIT_CYC  = `UHRS_LS_BIT_CYC
) (
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_rst_n,
  input  wire logic                     i_cmd_wr,
  input  wire logic [`UHRS_CMD_W-1:0]   i_host_transition_command,
  input  wire logic                     i_low_speed,
  input  wire logic                     i_disconnect_det_req,
  input  wire logic                     i_wakeup_det_req,
  input  wire logic                     i_resume_complete_clr,
  input  wire logic                     i_resume_complete_int_en,
  output logic [`UHRS_STATE_W-1:0]      o_host_state_monitor,
  output uhrs_xcvr_type                 o_host_transceiver_control,
  output uhrs_det_type                  o_det,
  output logic                          o_resume_complete_flag,
  output logic                          o_irq,
  output logic                          o_first_sof,
  output logic                          o_first_keepalive,
  output logic                          o_busy
);

  // ----------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------
  // Timer width covers the 20 ms K count at 25 MHz
  localparam int TW      = 20;
  // EOP phases; low-speed bit time even when a full-speed device is attached
  localparam int SE0_CYC = LS_BIT_CYC * `UHRS_EOP_SE0_BITS;
  localparam int J_CYC   = LS_BIT_CYC * `UHRS_EOP_J_BITS;

  // Phases of one resume
  typedef enum logic [2:0] {
    SQ_IDLE,
    SQ_K,
    SQ_EOP_SE0,
    SQ_EOP_J,
    SQ_CMP_WAIT,
    SQ_DONE,
    SQ_SOF_WAIT
  } uhrs_sq_type;

  // All state in one word; one comb copy, one register
  typedef struct packed {
    uhrs_sq_type                seq;
    logic [`UHRS_STATE_W-1:0]   host_state;
    uhrs_xcvr_type              xcvr;
    logic                       det_off;
    uhrs_det_type               det;
    logic                       ls_meta;
    logic                       ls_sync;
    logic                       cmp_flag;
    logic                       irq;
    logic                       sof;
    logic                       keepalive;
    logic [TW-1:0]              load_cnt;
    logic                       load;
  } uhrs_state_type;

  uhrs_state_type st;
  uhrs_state_type next_st;
  logic           tmr_done;

  // Cycles as timer width
  function automatic logic [TW-1:0] cyc(input int n);
    cyc = TW'(n);
  endfunction

  // Command strobe carrying one given code
  function automatic logic cmd_is(input logic                   wr,
                                  input logic [`UHRS_CMD_W-1:0] cmd,
                                  input logic [`UHRS_CMD_W-1:0] code);
    cmd_is = wr && cmd == code;
  endfunction

  // ----------------------------------------------------------------
  // Shared interval timer
  // ----------------------------------------------------------------
  // Phases never overlap, so one counter serves them all
  uhrs_timer #(
    .WIDTH (TW)
  ) u_timer (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_load    (st.load),
    .i_count   (st.load_cnt),
    .o_done    (tmr_done)
  );

  // ----------------------------------------------------------------
  // Sequence next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st           = st;
    next_st.load      = 1'b0;
    next_st.sof       = 1'b0;
    next_st.keepalive = 1'b0;
    // Two flops on the speed level, which comes from the line monitor
    next_st.ls_meta   = i_low_speed;
    next_st.ls_sync   = st.ls_meta;
    unique case (st.seq)
      SQ_IDLE, SQ_DONE: begin
        if (cmd_is(i_cmd_wr, i_host_transition_command, `UHRS_CMD_RESUME)) begin
          next_st.seq            = SQ_K;
          next_st.host_state     = `UHRS_STATE_RESUME;
          next_st.det_off        = 1'b1;
          next_st.xcvr.op_mode   = `UHRS_TRANSCEIVER_OPERATION_MODE_RAW;
          next_st.xcvr.raw_drive = 1'b1;
          next_st.xcvr.line      = UHRS_LINE_K;
          next_st.load           = 1'b1;
          next_st.load_cnt       = cyc(RSM_K_CYC);
        end else if (st.seq == SQ_DONE
                     && cmd_is(i_cmd_wr, i_host_transition_command, `UHRS_CMD_OPER)) begin
          next_st.seq          = SQ_SOF_WAIT;
          next_st.host_state   = `UHRS_STATE_OPER;
          next_st.xcvr.op_mode = `UHRS_TRANSCEIVER_OPERATION_MODE_NORMAL;
          next_st.xcvr.raw_drive = 1'b0;
          next_st.xcvr.line    = UHRS_LINE_J;
          next_st.det_off      = 1'b0;
          next_st.load         = 1'b1;
          next_st.load_cnt     = cyc(SOF_CYC);
        end
      end
      SQ_K: begin
        if (tmr_done) begin
          // LS bit timing even for full speed, as the far end may be asleep slow
          next_st.seq       = SQ_EOP_SE0;
          next_st.xcvr.line = UHRS_LINE_SE0;
          next_st.load      = 1'b1;
          next_st.load_cnt  = cyc(SE0_CYC);
        end
      end
      SQ_EOP_SE0: begin
        if (tmr_done) begin
          next_st.seq       = SQ_EOP_J;
          next_st.xcvr.line = UHRS_LINE_J;
          next_st.load      = 1'b1;
          next_st.load_cnt  = cyc(J_CYC);
        end
      end
      SQ_EOP_J: begin
        if (tmr_done) begin
          // Signalling ends here; complete counted from this edge
          next_st.seq            = SQ_CMP_WAIT;
          next_st.xcvr.raw_drive = 1'b0;
          next_st.load           = 1'b1;
          next_st.load_cnt       = cyc(CMP_CYC);
        end
      end
      SQ_CMP_WAIT: begin
        if (tmr_done) begin
          next_st.seq      = SQ_DONE;
          next_st.cmp_flag = 1'b1;
        end
      end
      SQ_SOF_WAIT: begin
        if (tmr_done) begin
          next_st.seq       = SQ_IDLE;
          next_st.sof       = !st.ls_sync;
          next_st.keepalive = st.ls_sync;
        end
      end
      default: begin
        next_st.seq = SQ_IDLE;
      end
    endcase
    // Sticky flag; a set in the clear cycle wins
    if (i_resume_complete_clr && !(st.seq == SQ_CMP_WAIT && tmr_done)) begin
      next_st.cmp_flag = 1'b0;
    end
    next_st.irq = next_st.cmp_flag && i_resume_complete_int_en;
    // Detectors off from time zero until the operational request
    next_st.det.disconnect_det_en = i_disconnect_det_req && !next_st.det_off;
    next_st.det.wakeup_det_en     = i_wakeup_det_req && !next_st.det_off;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Sync reset; idle line shows J with the port suspended
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st            <= '0;
      st.seq        <= SQ_IDLE;
      st.host_state <= `UHRS_STATE_SUSPEND;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_host_state_monitor       = st.host_state;
  assign o_host_transceiver_control = st.xcvr;
  // Registered gate; a request change shows one cycle later
  assign o_det                      = st.det;
  assign o_resume_complete_flag     = st.cmp_flag;
  assign o_irq                      = st.irq;
  assign o_first_sof                = st.sof;
  assign o_first_keepalive          = st.keepalive;
  // High from the request until complete or first SOF or KeepAlive
  assign o_busy                     = st.seq != SQ_IDLE && st.seq != SQ_DONE;

endmodule

// *** uhrs_sequencer_assertions.sv ***
`timescale 1ns/1ns
`include "uhrs_map.svh"
module uhrs_sequencer_assertions
  import uhrs_pkg::*;
#(
  parameter int RSM_K_CYC = `UHRS_RSM_K_CYC,
  parameter int CMP_CYC   = `UHRS_CMP_CYC,
  parameter int SOF_CYC   = `UHRS_SOF_CYC
) (
  input wire logic                     i_sys_clk,
  input wire logic                     i_rst_n,
  input wire logic                     i_cmd_wr,
  input wire logic [`UHRS_CMD_W-1:0]   i_host_transition_command,
  input wire logic                     i_low_speed,
  input wire logic                     i_resume_complete_clr,
  input wire logic                     i_resume_complete_int_en,
  input wire logic [`UHRS_STATE_W-1:0] o_host_state_monitor,
  input wire uhrs_xcvr_type            o_host_transceiver_control,
  input wire uhrs_det_type             o_det,
  input wire logic                     o_resume_complete_flag,
  input wire logic                     o_irq,
  input wire logic                     o_first_sof,
  input wire logic                     o_first_keepalive,
  input wire logic                     o_busy
);
  localparam int CMP_LO = CMP_CYC * 9 / 10;
  localparam int CMP_HI = CMP_CYC * 11 / 10 + 2;
  localparam int SOF_LO = SOF_CYC * 9 / 10;
  localparam int SOF_HI = SOF_CYC * 11 / 10 + 2;
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  logic [31:0]   t;
  logic [31:0]   k;
  uhrs_xcvr_type x;
  logic          rs;
  logic          op;
  // Accepted commands; counters avoid long delay ranges
  assign x  = o_host_transceiver_control;
  assign rs = i_cmd_wr && i_host_transition_command == `UHRS_CMD_RESUME && !o_busy;
  assign op = i_cmd_wr && i_host_transition_command == `UHRS_CMD_OPER && !o_busy
              && o_host_state_monitor == `UHRS_STATE_RESUME;
  // Cycles since end of drive or operational request, and K run length
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      t <= 32'h0000_0000;
      k <= 32'h0000_0000;
    end else begin
      t <= (op || $fell(x.raw_drive)) ? 32'h0000_0001 : t + 32'h0000_0001;
      k <= (x.line == UHRS_LINE_K) ? k + 32'h0000_0001 : 32'h0000_0000;
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // Bench runs with two clocks per low-speed bit; each phase adds two clocks of timer
  sequence s_eop;
    (x.line == UHRS_LINE_SE0 && x.raw_drive) [*6]
    ##1 (x.line == UHRS_LINE_J && x.raw_drive) [*4]
    ##1 (x.line == UHRS_LINE_J && !x.raw_drive);
  endsequence
  property p_state; rs |=> o_host_state_monitor == `UHRS_STATE_RESUME; endproperty
  property p_raw;
    rs |=> x.op_mode == `UHRS_TRANSCEIVER_OPERATION_MODE_RAW && x.raw_drive && x.line == UHRS_LINE_K;
  endproperty
  property p_det; x.raw_drive |-> o_det == 2'h0; endproperty
  property p_klen; $fell(x.line == UHRS_LINE_K) |-> k > RSM_K_CYC; endproperty
  property p_eop; $fell(x.line == UHRS_LINE_K) |-> s_eop; endproperty
  property p_cmp; $rose(o_resume_complete_flag) |-> t >= CMP_LO && t <= CMP_HI; endproperty
  property p_sticky; o_resume_complete_flag && !i_resume_complete_clr |=> o_resume_complete_flag;
  endproperty
  property p_irq; (o_resume_complete_flag && i_resume_complete_int_en) [*2] |-> o_irq; endproperty
  property p_oper;
    op |=> x.op_mode == `UHRS_TRANSCEIVER_OPERATION_MODE_NORMAL && o_host_state_monitor == `UHRS_STATE_OPER;
  endproperty
  property p_sof; o_first_sof |-> !i_low_speed && t >= SOF_LO && t <= SOF_HI; endproperty
  property p_ka; o_first_keepalive |-> i_low_speed && t >= SOF_LO && t <= SOF_HI; endproperty
  a_state:  assert property (p_state)  else $error("state not resume");
  a_raw:    assert property (p_raw)    else $error("no raw K drive");
  a_det:    assert property (p_det)    else $error("detector on in resume");
  a_klen:   assert property (p_klen)   else $error("K too short");
  a_eop:    assert property (p_eop)    else $error("bad end of packet");
  a_cmp:    assert property (p_cmp)    else $error("complete out of window");
  a_sticky: assert property (p_sticky) else $error("flag dropped");
  a_irq:    assert property (p_irq)    else $error("irq missing");
  a_oper:   assert property (p_oper)   else $error("not normal drive");
  a_sof:    assert property (p_sof)    else $error("sof timing");
  a_ka:     assert property (p_ka)     else $error("keepalive timing");
endmodule

// *** uhrs_sequencer_tb.sv ***
`timescale 1ns/1ns
`include "uhrs_map.svh"
module uhrs_sequencer_tb;
  import uhrs_pkg::*;
  localparam int RK = 50, CC = 10, SC = 20, LB = 2;
  logic clk = 0, rst_n = 0, wr = 0, ls = 0, clr = 0, en = 1, dq = 1, wq = 1;
  logic [3:0] cmd = 4'h0;
  logic [2:0] state;
  uhrs_xcvr_type xc;
  uhrs_det_type det;
  logic flag, irq, sof, ka, busy;
  logic [15:0] klen, slen;
  int fails = 0, num_checks = 0, n;
  uhrs_sequencer #(.RSM_K_CYC(RK), .CMP_CYC(CC), .SOF_CYC(SC), .LS_BIT_CYC(LB)) dut (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_cmd_wr(wr), .i_host_transition_command(cmd),
    .i_low_speed(ls), .i_disconnect_det_req(dq), .i_wakeup_det_req(wq),
    .i_resume_complete_clr(clr), .i_resume_complete_int_en(en),
    .o_host_state_monitor(state), .o_host_transceiver_control(xc), .o_det(det),
    .o_resume_complete_flag(flag), .o_irq(irq), .o_first_sof(sof),
    .o_first_keepalive(ka), .o_busy(busy));
  uhrs_dev_model dev (.i_sys_clk(clk), .i_line(xc.line), .o_k_len(klen), .o_se0_len(slen));
  always #20 clk = ~clk;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tick(input int c);
    repeat (c) @(posedge clk);
    #2;
  endtask
  task send(input logic [3:0] code);
    wr = 1;
    cmd = code;
    tick(1);
    wr = 0;
    // Strobe stays low a full cycle between commands
    tick(1);
  endtask
  // Bounded wait, so a silent design fails instead of hanging
  task wait_ev(input bit pulse, output int c);
    c = 0;
    while (c < 300 && ((pulse ? (sof | ka) : flag) !== 1'b1)) begin
      tick(1);
      c++;
    end
  endtask
  task stop_test;
    if (fails == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Full resume then operational at one speed
  task run(input logic low);
    ls = low;
    en = !low;
    dq = low;
    wq = !low;
    send(4'h3);
    chk(state, 3'h3);
    send(`UHRS_CMD_RESUME);
    chk({state, xc}, {3'h4, 2'h2, 1'b1, UHRS_LINE_K});
    chk({det, busy}, 3'h1);
    send(`UHRS_CMD_OPER);
    chk(xc.op_mode, 2'h2);
    wait_ev(0, n);
    chk(n >= RK + 3 * LB + CC * 9 / 10 && n <= RK + 3 * LB + CC * 11 / 10 + 6, 1'b1);
    chk({klen > RK, slen >= 2 * LB && slen <= 2 * LB + 2, xc.raw_drive}, 3'h6);
    tick(2);
    chk({flag, irq}, {1'b1, !low});
    send(`UHRS_CMD_OPER);
    chk({state, xc.op_mode, det}, {3'h5, 2'h0, low, !low});
    wait_ev(1, n);
    chk({n >= SC * 9 / 10 - 1 && n <= SC * 11 / 10 + 1, sof, ka}, {1'b1, !low, low});
    clr = 1;
    tick(1);
    clr = 0;
    tick(1);
    chk({flag, irq}, 2'h0);
  endtask
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    tick(12);
    rst_n = 1;
    chk({state, xc, flag, busy}, {3'h3, 2'h0, 1'b0, UHRS_LINE_J, 2'h0});
    run(0);
    rst_n = 0;
    tick(2);
    rst_n = 1;
    run(1);
    stop_test;
  end
  initial begin
    #(40 * 3000);
    fails++;
    stop_test;
  end
endmodule
bind uhrs_sequencer uhrs_sequencer_assertions #(
  .RSM_K_CYC(RSM_K_CYC), .CMP_CYC(CMP_CYC), .SOF_CYC(SOF_CYC)) u_chk (
  .i_sys_clk, .i_rst_n, .i_cmd_wr, .i_host_transition_command, .i_low_speed,
  .i_resume_complete_clr, .i_resume_complete_int_en, .o_host_state_monitor,
  .o_host_transceiver_control, .o_det, .o_resume_complete_flag, .o_irq,
  .o_first_sof, .o_first_keepalive, .o_busy);

// *** uhrs_timer.sv ***
`timescale 1ns/1ns
// Down counter: load a count, pulse done the cycle after it reaches one
module uhrs_timer
  import uhrs_pkg::*;
#(
  parameter int WIDTH = 20
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_load,
  input  wire logic [WIDTH-1:0] i_count,
  output logic                  o_done
);

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic             run;
    logic             done;
  } uhrs_timer_type;

  uhrs_timer_type st;
  uhrs_timer_type next_st;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    if (i_load) begin
      next_st.cnt = i_count;
      next_st.run = 1'b1;
    end else if (st.run) begin
      if (st.cnt <= WIDTH'(1)) begin
        next_st.run  = 1'b0;
        next_st.done = 1'b1;
      end else begin
        next_st.cnt = st.cnt - WIDTH'(1);
      end
    end
  end

  // Registers
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_done = st.done;

endmodule
